// ==== logic/bmc_params.svh ====
// Offsets, field positions, first characters and timing figures of the bootstrap mode control.
`ifndef BMC_PARAMS_SVH
`define BMC_PARAMS_SVH
`define BMC_ADDR_W        8
`define BMC_OFF_MODE      8'h00
`define BMC_OFF_BAUD      8'h04
`define BMC_OFF_RXDATA    8'h08
`define BMC_BIT_EXP       0
`define BMC_BIT_SPC       1
`define BMC_BIT_BOOT      2
`define BMC_BIT_UNSEC     3
`define BMC_BIT_SECURED   4
`define BMC_BIT_ALT       0
`define BMC_BIT_FIRST     1
`define BMC_BIT_FERR      2
`define BMC_BIT_RXVALID   3
`define BMC_FIRST_LSB     8
`define BMC_CLK_HZ        100000000
`define BMC_BAUD_HI       7812
`define BMC_BAUD_LO       1200
`define BMC_TIMEOUT_BITS  40
`define BMC_BOOT_ROM_BYTES 192
`define BMC_CHAR_DEFAULT  8'hFF
`define BMC_CHAR_ALT_A    8'hC0
`define BMC_CHAR_ALT_B    8'hE0
`define BMC_DATA_BITS     8
`endif

// ==== logic/bmc_pkg.sv ====
// Types shared by the bootstrap mode control logic.
package bmc_pkg;
  typedef struct packed {
    logic unsec;
    logic boot_en;
    logic special;
    logic expanded;
  } bmc_mode_s;

  typedef enum logic [1:0] {
    BMC_RX_IDLE  = 2'b00,
    BMC_RX_START = 2'b01,
    BMC_RX_DATA  = 2'b10,
    BMC_RX_STOP  = 2'b11
  } bmc_rx_state_e;
endpackage

// ==== logic/bmc_top.sv ====
// Bootstrap mode control: reset mode capture, boot ROM and vector control, baud discrimination.
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "bmc_params.svh"

// How it works
// - At reset release the expansion-select pin is copied into the expanded mode bit.
// - At reset release the special mode bit takes the inverted special-select pin.
// - The two pins decode into the four modes; mode bits follow that decode.
// - Boot ROM enable resets to one in special bootstrap, zero otherwise.
// - Boot ROM enable is writable only in special modes; reads zero in normal modes.
// - The 192-byte boot ROM is mapped only while boot ROM enable is one.
// - With special mode set, A14 is forced low on every vector fetch.
// - Software writes to mode bits take effect only while special mode is set.
// - A secured part ignores the expansion-select pin at reset.
// - Security is released through bootstrap only after EEPROM and RAM are erased.
// - First char 0xFF keeps the higher rate; 0xC0 or 0xE0 means the lower rate.
// - Start edge confirmed mid-bit, data sampled at centres, stop sample must be one.
// - After the lower-rate pattern, bit time and character timeout are rescaled.
module bmc_top #(
  parameter int unsigned BIT_HI_CYC = `BMC_CLK_HZ / `BMC_BAUD_HI,
  parameter int unsigned BIT_LO_CYC = `BMC_CLK_HZ / `BMC_BAUD_LO
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`BMC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  input  wire logic                   expansion_select_pin,
  input  wire logic                   special_select_pin_n,
  input  wire logic                   security_disable_bit,
  input  wire logic                   erase_done,
  input  wire logic                   vector_fetch,
  input  wire logic                   cpu_addr_a14,
  output logic                        addr_a14,
  output logic                        boot_rom_mapped,
  output logic                        expanded_mode_bit,
  output logic                        special_mode_bit,
  input  wire logic                   rxd,
  output logic                        rx_valid,
  output logic [7:0]                  rx_data,
  output logic                        baud_alt,
  output logic [31:0]                 char_timeout_cyc
);

  // Long bit times are parameters so a bench can shorten them.
  if (BIT_HI_CYC < 4 || BIT_LO_CYC <= BIT_HI_CYC) begin : g_check
    $error("bmc_top: bit times must be at least 4 and the low rate slower");
  end

  // True for a first character that betrays a host sending at the lower rate.
  function automatic logic is_alt_char(input logic [7:0] c);
    is_alt_char = (c == `BMC_CHAR_ALT_A) || (c == `BMC_CHAR_ALT_B);
  endfunction

  // ---------------- Mode, vectors and bus ----------------
  bmc_pkg::bmc_mode_s mode_reg, mode_next;
  logic               capture_reg, capture_next;
  logic               a14_reg, a14_next;
  logic               pready_reg, pready_next;
  logic               pslverr_reg, pslverr_next;
  logic [31:0]        prdata_reg, prdata_next;
  logic               secured;
  logic               wr_en;
  logic               acc;

  // Rx-side state that the bus reads back.
  logic               alt_reg;
  logic               first_reg;
  logic               ferr_reg;
  logic               rxv_reg;
  logic [7:0]         first_char_reg;
  logic [7:0]         rxd_reg;

  // A secured part sees the expansion pin as zero, so the special pin alone picks the mode.
  assign secured = ~security_disable_bit & ~mode_reg.unsec;
  assign acc     = psel & penable;
  // Writes land only at the edge that samples pready high, after which the master releases.
  assign wr_en   = acc & pready_reg & pwrite;

  // Next values of the mode bits, the A14 gate and the APB answer.
  always_comb begin
    mode_next    = mode_reg;
    capture_next = 1'b0;
    // sample at release
    // Pins count only at this one edge; afterwards software alone may move the bits.
    if (capture_reg) begin
      mode_next.expanded = expansion_select_pin & ~secured;
      mode_next.special  = ~special_select_pin_n;
      mode_next.boot_en  = ~special_select_pin_n & ~(expansion_select_pin & ~secured);
    end else if (wr_en && paddr == `BMC_OFF_MODE) begin
      if (mode_reg.special) begin
        mode_next.expanded = pwdata[`BMC_BIT_EXP];
        mode_next.special  = pwdata[`BMC_BIT_SPC];
        mode_next.boot_en  = pwdata[`BMC_BIT_BOOT];
        // unsecure only after erase
        // Only bootstrap may unsecure; special test would expose memory to the bus.
        if (pwdata[`BMC_BIT_UNSEC] && erase_done && !mode_reg.expanded) begin
          mode_next.unsec = 1'b1;
        end
      end
    end
    if (!mode_next.special) begin
      mode_next.boot_en = 1'b0;
    end
    a14_next = cpu_addr_a14 & ~(vector_fetch & mode_reg.special);
    // One wait state: pready rises in the second access cycle.
    pready_next  = acc & ~pready_reg;
    pslverr_next = 1'b0;
    // Read data stays zero outside the answer cycle, so no idle value leaks onto the bus.
    prdata_next  = 32'h0000_0000;
    if (acc && !pready_reg) begin
      case (paddr)
        `BMC_OFF_MODE: begin
          prdata_next[`BMC_BIT_EXP]     = mode_reg.expanded;
          prdata_next[`BMC_BIT_SPC]     = mode_reg.special;
          prdata_next[`BMC_BIT_BOOT]    = mode_reg.boot_en;
          prdata_next[`BMC_BIT_UNSEC]   = mode_reg.unsec;
          prdata_next[`BMC_BIT_SECURED] = secured;
        end
        `BMC_OFF_BAUD: begin
          prdata_next[`BMC_BIT_ALT]     = alt_reg;
          prdata_next[`BMC_BIT_FIRST]   = first_reg;
          prdata_next[`BMC_BIT_FERR]    = ferr_reg;
          prdata_next[`BMC_BIT_RXVALID] = rxv_reg;
          prdata_next[`BMC_FIRST_LSB +: 8] = first_char_reg;
        end
        `BMC_OFF_RXDATA: begin
          prdata_next[7:0] = rxd_reg;
        end
        default: begin
          pslverr_next = 1'b1;
        end
      endcase
    end
  end

  // Registers of the mode group; capture is armed by reset and fires once after release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg    <= '0;
      capture_reg <= 1'b1;
      a14_reg     <= 1'b0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      mode_reg    <= mode_next;
      capture_reg <= capture_next;
      a14_reg     <= a14_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg  <= prdata_next;
    end
  end

  // ---------------- Serial receiver and baud discrimination ----------------
  bmc_pkg::bmc_rx_state_e st_reg, st_next;
  logic [31:0]        cnt_reg, cnt_next;
  logic [2:0]         bit_reg, bit_next;
  logic [7:0]         sh_reg, sh_next;
  logic               rx_prev_reg, rx_prev_next;
  logic               alt_next, first_next, ferr_next, rxv_next;
  logic [7:0]         first_char_next, rxd_next;
  logic [31:0]        tmo_reg, tmo_next;
  logic [31:0]        bit_cyc;

  assign bit_cyc = alt_reg ? BIT_LO_CYC : BIT_HI_CYC;

  // Receiver sequence; a long zero at the lower rate looks like 0xC0 or 0xE0 here.
  always_comb begin
    st_next         = st_reg;
    cnt_next        = cnt_reg;
    bit_next        = bit_reg;
    sh_next         = sh_reg;
    rx_prev_next    = rxd;
    alt_next        = alt_reg;
    first_next      = first_reg;
    ferr_next       = ferr_reg;
    rxv_next        = 1'b0;
    first_char_next = first_char_reg;
    rxd_next        = rxd_reg;
    // timeout follows bit time
    // The timeout tracks the current rate, so it rescales one cycle after the switch.
    tmo_next        = 32'(bit_cyc * `BMC_TIMEOUT_BITS);
    if (cnt_reg != 32'h0000_0000) begin
      cnt_next = cnt_reg - 32'h0000_0001;
    end
    case (st_reg)
      bmc_pkg::BMC_RX_IDLE: begin
        if (rx_prev_reg && !rxd) begin
          st_next  = bmc_pkg::BMC_RX_START;
          // Two cycles come off the half bit: one lost to edge detection and one to the
          // zero test, so the confirm sample lands on the centre of the start bit.
          cnt_next = (bit_cyc >> 1) - 32'h0000_0002;
        end
      end
      bmc_pkg::BMC_RX_START: begin
        if (cnt_reg == 32'h0000_0000) begin
          st_next  = rxd ? bmc_pkg::BMC_RX_IDLE : bmc_pkg::BMC_RX_DATA;
          cnt_next = bit_cyc - 32'h0000_0001;
          bit_next = 3'h0;
        end
      end
      bmc_pkg::BMC_RX_DATA: begin
        if (cnt_reg == 32'h0000_0000) begin
          sh_next  = {rxd, sh_reg[7:1]};
          cnt_next = bit_cyc - 32'h0000_0001;
          bit_next = bit_reg + 3'h1;
          if (bit_reg == 3'(`BMC_DATA_BITS - 1)) begin
            st_next = bmc_pkg::BMC_RX_STOP;
          end
        end
      end
      bmc_pkg::BMC_RX_STOP: begin
        if (cnt_reg == 32'h0000_0000) begin
          st_next = bmc_pkg::BMC_RX_IDLE;
          ferr_next = ~rxd;
          if (rxd) begin
            rxv_next = 1'b1;
            rxd_next = sh_reg;
            if (!first_reg) begin
              first_next      = 1'b1;
              first_char_next = sh_reg;
              alt_next        = is_alt_char(sh_reg);
            end
          end
        end
      end
      default: begin
        st_next = bmc_pkg::BMC_RX_IDLE;
      end
    endcase
  end

  // Registers of the receiver; the line idles high, so the edge detector resets high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg         <= bmc_pkg::BMC_RX_IDLE;
      cnt_reg        <= 32'h0000_0000;
      bit_reg        <= 3'h0;
      sh_reg         <= 8'h00;
      rx_prev_reg    <= 1'b1;
      alt_reg        <= 1'b0;
      first_reg      <= 1'b0;
      ferr_reg       <= 1'b0;
      rxv_reg        <= 1'b0;
      first_char_reg <= 8'h00;
      rxd_reg        <= 8'h00;
      tmo_reg        <= 32'h0000_0000;
    end else begin
      st_reg         <= st_next;
      cnt_reg        <= cnt_next;
      bit_reg        <= bit_next;
      sh_reg         <= sh_next;
      rx_prev_reg    <= rx_prev_next;
      alt_reg        <= alt_next;
      first_reg      <= first_next;
      ferr_reg       <= ferr_next;
      rxv_reg        <= rxv_next;
      first_char_reg <= first_char_next;
      rxd_reg        <= rxd_next;
      tmo_reg        <= tmo_next;
    end
  end

  // All outputs come from flip-flops.
  assign pready            = pready_reg;
  assign prdata            = prdata_reg;
  assign pslverr           = pslverr_reg;
  assign addr_a14          = a14_reg;
  assign boot_rom_mapped   = mode_reg.boot_en;
  assign expanded_mode_bit = mode_reg.expanded;
  assign special_mode_bit  = mode_reg.special;
  assign rx_valid          = rxv_reg;
  assign rx_data           = rxd_reg;
  assign baud_alt          = alt_reg;
  assign char_timeout_cyc  = tmo_reg;

endmodule

// ==== sim/bmc_assertions.sv ====
// Concurrent checks on the ports of the bootstrap mode control.
`timescale 1ns/10ps
module bmc_assertions #(
  parameter int unsigned BIT_HI_CYC = 8,
  parameter int unsigned BIT_LO_CYC = 52
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        vector_fetch,
  input wire logic        addr_a14,
  input wire logic        boot_rom_mapped,
  input wire logic        expanded_mode_bit,
  input wire logic        special_mode_bit,
  input wire logic        expansion_select_pin,
  input wire logic        special_select_pin_n,
  input wire logic        security_disable_bit,
  input wire logic        rx_valid,
  input wire logic        baud_alt,
  input wire logic [31:0] char_timeout_cyc
);
  logic [1:0] up_reg;
  logic [1:0] up_next;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Edges since reset release; pins are captured at the first, so older values are not trusted.
  always_comb begin
    up_next = (up_reg == 2'h2) ? up_reg : up_reg + 2'h1;
  end

  // Saturating counter register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_reg <= 2'h0;
    end else begin
      up_reg <= up_next;
    end
  end

  mode_capture_a: assert property (up_reg == 2'h1 |->
    expanded_mode_bit == ($past(expansion_select_pin) && $past(security_disable_bit))
    && special_mode_bit == !$past(special_select_pin_n)) else $error("mode capture wrong");
  boot_reset_a: assert property (up_reg == 2'h1 |->
    boot_rom_mapped == (special_mode_bit && !expanded_mode_bit)) else $error("boot rom reset");
  boot_normal_a: assert property (!special_mode_bit |-> !boot_rom_mapped)
    else $error("boot rom in normal mode");
  a14_forced_a: assert property (vector_fetch && special_mode_bit |=> !addr_a14)
    else $error("a14 not forced");
  mode_locked_a: assert property (up_reg == 2'h2 && !special_mode_bit |=>
    $stable(expanded_mode_bit) && !special_mode_bit) else $error("mode bits moved");
  baud_sticky_a: assert property (baud_alt |=> baud_alt)
    else $error("rate fell back");
  timeout_scale_a: assert property (up_reg == 2'h2 && $stable(baud_alt) |->
    char_timeout_cyc == 40 * (baud_alt ? BIT_LO_CYC : BIT_HI_CYC)) else $error("timeout");
  rx_pulse_a: assert property (rx_valid |=> !rx_valid)
    else $error("rx_valid too long");
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
endmodule

// ==== sim/bmc_host_model.sv ====
// Host computer on the serial receive line.
`timescale 1ns/10ps
module bmc_host_model (
  input wire logic pclk,
  output logic     rxd
);
  // The line idles high between characters.
  initial begin
    rxd = 1'b1;
  end

  // host character framing
  // Start, eight bits LSB first, stop; stop_ok low breaks the frame on purpose.
  task automatic send(input logic [7:0] ch, input int unsigned cyc, input logic stop_ok);
    logic [9:0] frame;
    frame = {stop_ok, ch, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= frame[i];
      repeat (cyc) @(posedge pclk);
    end
    rxd <= 1'b1;
  endtask
endmodule

// ==== sim/test_bootstrap_mode_control.sv ====
// Self-checking testbench for the bootstrap mode control.
`timescale 1ns/10ps
`include "bmc_params.svh"
module test_bootstrap_mode_control;
  localparam int unsigned HI = 8;
  localparam int unsigned LO = 52;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, char_timeout_cyc, rd;
  logic pready, pslverr, addr_a14, boot_rom_mapped, expanded_mode_bit, special_mode_bit;
  logic expansion_select_pin = 1'b0, special_select_pin_n = 1'b1, security_disable_bit = 1'b1;
  logic erase_done = 1'b0, vector_fetch = 1'b0, cpu_addr_a14 = 1'b0, rxd, rx_valid, baud_alt;
  logic [7:0] rx_data, d;
  logic sn, ex, sec, sm, ea, un, err, seen;
  int fail_count = 0;
  int checks_done = 0;

  // Free-running 100 MHz clock.
  always #5 pclk = ~pclk;

  bmc_top #(.BIT_HI_CYC(HI), .BIT_LO_CYC(LO)) i_bmc_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .expansion_select_pin(expansion_select_pin), .special_select_pin_n(special_select_pin_n),
    .security_disable_bit(security_disable_bit), .erase_done(erase_done),
    .vector_fetch(vector_fetch), .cpu_addr_a14(cpu_addr_a14), .addr_a14(addr_a14),
    .boot_rom_mapped(boot_rom_mapped), .expanded_mode_bit(expanded_mode_bit),
    .special_mode_bit(special_mode_bit), .rxd(rxd), .rx_valid(rx_valid), .rx_data(rx_data),
    .baud_alt(baud_alt), .char_timeout_cyc(char_timeout_cyc));
  bmc_host_model i_bmc_host_model (.pclk(pclk), .rxd(rxd));

  // Comparisons count every call; a mismatch is reported at once.
  task automatic chkw(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp, input string what);
    chkw({31'h0, got}, {31'h0, exp}, what);
  endtask

  // One APB transfer; the request holds until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED at %0t: apb answer timed out", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reset with the given pins, held for 8 cycles.
  task automatic rst(input logic s_n, input logic e, input logic s);
    @(posedge pclk);
    presetn <= 1'b0;
    special_select_pin_n <= s_n;
    expansion_select_pin <= e;
    security_disable_bit <= s;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask

  // Sends one character and waits, bounded, for its receive pulse.
  task automatic xfer(input logic [7:0] ch, input int unsigned cyc, input logic ok);
    seen = 1'b0;
    fork
      i_bmc_host_model.send(ch, cyc, ok);
      for (int n = 0; n < 1000 && !seen; n++) begin
        @(posedge pclk);
        if (rx_valid === 1'b1) begin
          seen = 1'b1;
          d = rx_data;
        end
      end
    join
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Rows 0..3 walk the four pin pairs; rows 4 and 5 are a secured part.
  initial begin
    for (int i = 0; i < 6; i++) begin
      sec = (i < 4);
      sn = (i < 4) ? i[1] : i[0];
      ex = (i < 4) ? i[0] : 1'b1;
      sm = !sn;
      ea = ex && sec;
      erase_done <= (i == 4);
      rst(sn, ex, sec);
      un = sm && !ea && (i == 4);
      chkb(expanded_mode_bit, ea, "expanded bit");
      chkb(special_mode_bit, sm, "special bit");
      chkb(boot_rom_mapped, sm && !ea, "boot rom at reset");
      vector_fetch <= 1'b1;
      cpu_addr_a14 <= 1'b1;
      expansion_select_pin <= !ex;
      special_select_pin_n <= !sn;
      repeat (2) @(posedge pclk);
      chkb(addr_a14, !sm, "vector a14");
      chkb(expanded_mode_bit, ea, "expanded held");
      chkb(special_mode_bit, sm, "special held");
      vector_fetch <= 1'b0;
      apb(1'b1, `BMC_OFF_MODE, 32'h0000000E);
      apb(1'b0, `BMC_OFF_MODE, 32'h0);
      chkw(rd & 32'hF, sm ? {28'h0, un, 3'h6} : {31'h0, ea}, "mode reg");
      chkb(rd[`BMC_BIT_SECURED], !sec && !un, "secured flag");
      chkb(boot_rom_mapped, sm, "boot rom after write");
      $display("Mode row %0d done", i);
    end
    apb(1'b0, 8'h0C, 32'h0);
    chkb(err, 1'b1, "unmapped error");
    rst(1'b0, 1'b0, 1'b1);
    xfer(8'hFF, HI, 1'b1);
    chkw({24'h0, d}, 32'hFF, "char at high rate");
    chkb(baud_alt, 1'b0, "rate kept");
    chkw(char_timeout_cyc, 40 * HI, "high timeout");
    rst(1'b0, 1'b0, 1'b1);
    xfer(8'hFF, LO, 1'b1);
    chkb(baud_alt, 1'b1, "rate switched");
    chkw(char_timeout_cyc, 40 * LO, "low timeout");
    xfer(8'h5A, LO, 1'b1);
    chkw({24'h0, d}, 32'h5A, "char at low rate");
    xfer(8'h55, LO, 1'b0);
    chkb(seen, 1'b0, "broken frame dropped");
    apb(1'b0, `BMC_OFF_BAUD, 32'h0);
    chkb(rd[`BMC_BIT_FERR], 1'b1, "frame error flag");
    chkb(rd[`BMC_BIT_ALT] && rd[`BMC_BIT_FIRST], 1'b1, "rate flags");
    d = rd[`BMC_FIRST_LSB +: 8];
    chkb(d == `BMC_CHAR_ALT_A || d == `BMC_CHAR_ALT_B, 1'b1, "first char");
    apb(1'b0, `BMC_OFF_RXDATA, 32'h0);
    chkw(rd, 32'h5A, "last char reg");
    $display("Serial test done");
    results();
  end

  // Watchdog well beyond the expected run.
  initial begin
    #200000;
    fail_count++;
    results();
  end
endmodule

bind bmc_top bmc_assertions #(.BIT_HI_CYC(BIT_HI_CYC), .BIT_LO_CYC(BIT_LO_CYC))
  i_bmc_assertions (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .vector_fetch(vector_fetch), .addr_a14(addr_a14),
  .boot_rom_mapped(boot_rom_mapped), .expanded_mode_bit(expanded_mode_bit),
  .special_mode_bit(special_mode_bit), .expansion_select_pin(expansion_select_pin),
  .special_select_pin_n(special_select_pin_n), .security_disable_bit(security_disable_bit),
  .rx_valid(rx_valid), .baud_alt(baud_alt), .char_timeout_cyc(char_timeout_cyc));
